// ---- verilog/trc_defs.svh ----
// offsets, field positions, reset values and codes of the touch report block
`ifndef TRC_DEFS_SVH
`define TRC_DEFS_SVH
`define TRC_OFF_CTRL      12'h000
`define TRC_OFF_STATUS    12'h004
`define TRC_OFF_CAL_SEL   12'h008
`define TRC_OFF_CAL_DATA  12'h00C
`define TRC_CTRL_MODE_LSB 0
`define TRC_CTRL_CHK_BIT  4
`define TRC_CTRL_FOC_LSB  8
`define TRC_MODE_RST      2'h2
`define TRC_CHK_RST       1'h1
`define TRC_FOCUS_RST     6'h04
`define TRC_MODE_LIFT     2'h0
`define TRC_MODE_TOUCH    2'h1
`define TRC_MODE_STREAM   2'h2
`define TRC_CMD_CAL       8'hBD
`define TRC_CMD_CHK       8'hA5
`define TRC_REP_OK        8'hC4
`define TRC_REP_ERR       8'hC8
`define TRC_REP_UNCHK     8'hC8
`define TRC_REP_PASS      8'hCB
`define TRC_REP_FAIL      8'hCC
`define TRC_SET_2         4'h2
`define TRC_SET_5         4'h5
`define TRC_SET_13        4'hD
`define TRC_REF_LO        10'h07F
`define TRC_REF_MID       10'h1FF
`define TRC_REF_HI        10'h37F
`define TRC_REF_IN_HI     10'h26F
`define TRC_REF_IN_LO     10'h13F
`define TRC_WIN           11'h07F
`endif

// ---- verilog/trc_pkg.sv ----
// shared types of the touch report block
package trc_pkg;
	typedef logic [9:0] trc_coord_t;
	typedef enum logic [2:0] {
		CAL_IDLE,
		CAL_PARAM,
		CAL_ECHO_OP,
		CAL_ECHO_PAR,
		CAL_TOUCH,
		CAL_POINT,
		CAL_TEST
	} trc_cal_e;
endpackage : trc_pkg

// ---- verilog/trc_cal_ref.sv ----
// reference position lookup and acceptance window of one calibration point
`timescale 1ns/1ps
`include "trc_defs.svh"
module trc_cal_ref (
	input  wire logic [3:0]        i_idx,
	input  wire trc_pkg::trc_coord_t i_x,
	input  wire trc_pkg::trc_coord_t i_y,
	output trc_pkg::trc_coord_t    o_ref_x,
	output trc_pkg::trc_coord_t    o_ref_y,
	output logic                   o_in_win
);
	logic [10:0] dx;
	logic [10:0] dy;
	logic [10:0] mx;
	logic [10:0] my;

	// sets of two and five are prefixes of the thirteen point table
	always_comb begin
		o_ref_x = `TRC_REF_MID;
		o_ref_y = `TRC_REF_MID;
		case (i_idx)
			4'h1: begin o_ref_x = `TRC_REF_LO;    o_ref_y = `TRC_REF_LO;    end // R7
			4'h2: begin o_ref_x = `TRC_REF_HI;    o_ref_y = `TRC_REF_HI;    end // R7
			4'h3: begin o_ref_x = `TRC_REF_LO;    o_ref_y = `TRC_REF_HI;    end
			4'h4: begin o_ref_x = `TRC_REF_MID;   o_ref_y = `TRC_REF_MID;   end
			4'h5: begin o_ref_x = `TRC_REF_HI;    o_ref_y = `TRC_REF_LO;    end
			4'h6: begin o_ref_x = `TRC_REF_HI;    o_ref_y = `TRC_REF_MID;   end
			4'h7: begin o_ref_x = `TRC_REF_MID;   o_ref_y = `TRC_REF_HI;    end
			4'h8: begin o_ref_x = `TRC_REF_LO;    o_ref_y = `TRC_REF_MID;   end
			4'h9: begin o_ref_x = `TRC_REF_MID;   o_ref_y = `TRC_REF_LO;    end
			4'hA: begin o_ref_x = `TRC_REF_IN_HI; o_ref_y = `TRC_REF_IN_LO; end // R8
			4'hB: begin o_ref_x = `TRC_REF_IN_HI; o_ref_y = `TRC_REF_IN_HI; end // R8
			4'hC: begin o_ref_x = `TRC_REF_IN_LO; o_ref_y = `TRC_REF_IN_HI; end // R8
			4'hD: begin o_ref_x = `TRC_REF_IN_LO; o_ref_y = `TRC_REF_IN_LO; end // R8
			default: begin o_ref_x = `TRC_REF_MID; o_ref_y = `TRC_REF_MID; end
		endcase
	end

	assign dx = {1'b0, i_x} - {1'b0, o_ref_x};
	assign dy = {1'b0, i_y} - {1'b0, o_ref_y};
	assign mx = dx[10] ? (~dx + 11'h001) : dx;
	assign my = dy[10] ? (~dy + 11'h001) : dy;
	assign o_in_win = (mx <= `TRC_WIN) && (my <= `TRC_WIN); // R9
endmodule : trc_cal_ref

// ---- verilog/trc_top.sv ----
// coordinate focus filter, report modes and calibration command handling
//
// Summary of operation
// R1: send and store coordinate when moved enough
// R2: small moves resend the stored coordinate
// R3: threshold 0..63, default 4, zero disables
// R4: liftoff mode sends last coordinate at release
// R5: touchdown mode sends first coordinate only
// R6: streaming mode sends every coordinate while touched; code sends none from an accepted parameter byte until idle again
// R7: two, five or thirteen point sets
// R8: points ten to thirteen use inner references
// R9: checked touch must sit within 127 counts
// R10: host sends opcode then count/index byte
// R11: echo both calibration bytes, then await touch
// R12: unchecked touch always gets the error reply
// R13: toggle command flips point checking
// R14: after last point, self-test and pass/fail reply
// R15: host repeats calibration after a failure reply
// R16: accepted points kept in storage
// R17: filter input is the delta-accepted coordinate
// R18: checked touch inside window replies OK
// R19: checked touch outside window replies error
// R20: one mode at a time, nothing without touch
// R21: bad index or count byte is ignored
`timescale 1ns/1ps
`include "trc_defs.svh"
module trc_top #(
	parameter int NPTS = 13
) (
	input  wire logic                i_clk,
	input  wire logic                i_rst_n,
	input  wire logic                i_psel,
	input  wire logic                i_penable,
	input  wire logic                i_pwrite,
	input  wire logic [11:0]         i_paddr,
	input  wire logic [31:0]         i_pwdata,
	output logic      [31:0]         o_prdata,
	output logic                     o_pready,
	output logic                     o_pslverr,
	input  wire logic                i_touch,
	input  wire logic                i_coord_valid,
	input  wire trc_pkg::trc_coord_t i_coord_x,
	input  wire trc_pkg::trc_coord_t i_coord_y,
	output logic                     o_rep_valid,
	output trc_pkg::trc_coord_t      o_rep_x,
	output trc_pkg::trc_coord_t      o_rep_y,
	input  wire logic                i_rx_valid,
	input  wire logic [7:0]          i_rx_byte,
	output logic                     o_tx_valid,
	output logic      [7:0]          o_tx_byte,
	input  wire logic                i_tx_ready
);
	trc_pkg::trc_cal_e   state;
	trc_pkg::trc_cal_e   next_state;
	logic [1:0]          mode;
	logic                chk_en;
	logic [5:0]          focus;
	logic [3:0]          cal_sel;
	logic                touch_m;
	logic                touch_s;
	logic                touch_d;
	logic                td_pend;
	logic                lift_have;
	trc_pkg::trc_coord_t last_c [2];
	trc_pkg::trc_coord_t prev_c [2];
	trc_pkg::trc_coord_t in_c   [2];
	trc_pkg::trc_coord_t filt_c [2];
	logic [1:0]          move;
	logic [7:0]          par;
	logic                pt_in;
	logic                pt_chk;
	logic                test_done;
	logic                test_pass;
	trc_pkg::trc_coord_t pt_x [NPTS];
	trc_pkg::trc_coord_t pt_y [NPTS];
	logic [NPTS-1:0]     pt_ok;
	logic [NPTS-1:0]     pt_need;

	// apb decode; one wait state keeps the read data registered
	wire apb_acc   = i_psel && i_penable && !o_pready;
	wire apb_done  = i_psel && i_penable && o_pready;
	wire apb_wr    = apb_done && i_pwrite;
	wire hit_ctrl  = (i_paddr == `TRC_OFF_CTRL);
	wire hit_stat  = (i_paddr == `TRC_OFF_STATUS);
	wire hit_sel   = (i_paddr == `TRC_OFF_CAL_SEL);
	wire hit_data  = (i_paddr == `TRC_OFF_CAL_DATA);
	wire hit_any   = hit_ctrl || hit_stat || hit_sel || hit_data;
	wire wr_ctrl   = apb_wr && hit_ctrl;
	wire [1:0] wr_mode = i_pwdata[`TRC_CTRL_MODE_LSB +: 2];
	wire mode_ok   = (wr_mode != 2'h3);
	wire sel_ok    = (cal_sel < 4'(NPTS));
	wire [31:0] rd_ctrl = {18'h00000, focus, 3'h0, chk_en, 2'h0, mode};
	wire [31:0] rd_stat = {16'h0000, 4'(state), 8'h00, test_pass, test_done,
		(state != trc_pkg::CAL_IDLE), touch_s};
	wire [31:0] rd_data = sel_ok ? {pt_ok[cal_sel], 5'h00, pt_x[cal_sel], 6'h00, pt_y[cal_sel]} : 32'h00000000;
	wire [31:0] rd_mux = hit_ctrl ? rd_ctrl :
		hit_stat ? rd_stat :
		hit_sel  ? {28'h0000000, cal_sel} :
		hit_data ? rd_data : 32'h00000000;

	// calibration command decode
	wire rx_idle   = i_rx_valid && (state == trc_pkg::CAL_IDLE);
	wire chk_tog   = rx_idle && (i_rx_byte == `TRC_CMD_CHK);
	wire [3:0] p_cnt = i_rx_byte[7:4];
	wire [3:0] p_idx = i_rx_byte[3:0];
	wire set_ok    = (p_cnt == `TRC_SET_2) || (p_cnt == `TRC_SET_5) || (p_cnt == `TRC_SET_13);
	wire param_ok  = set_ok && (p_idx != 4'h0) && (p_idx <= p_cnt);
	wire param_take = i_rx_valid && (state == trc_pkg::CAL_PARAM) && param_ok;
	wire cal_take  = (state == trc_pkg::CAL_TOUCH) && i_coord_valid && touch_s;
	wire win_ok;
	wire pt_acc    = !pt_chk || pt_in;
	wire last_pt   = (par[3:0] == par[7:4]);
	wire tx_done   = o_tx_valid && i_tx_ready;
	wire self_pass = &(pt_ok | ~pt_need);
	wire store     = cal_take && (!chk_en || win_ok);
	wire [7:0] pt_byte = !pt_chk ? `TRC_REP_UNCHK : (pt_in ? `TRC_REP_OK : `TRC_REP_ERR);
	wire is_send   = (state == trc_pkg::CAL_ECHO_OP) || (state == trc_pkg::CAL_ECHO_PAR) ||
		(state == trc_pkg::CAL_POINT) || (state == trc_pkg::CAL_TEST);
	wire tx_load   = is_send && !o_tx_valid;
	wire [7:0] tx_sel = (state == trc_pkg::CAL_ECHO_OP)  ? `TRC_CMD_CAL :
		(state == trc_pkg::CAL_ECHO_PAR) ? par :
		(state == trc_pkg::CAL_POINT)    ? pt_byte :
		(test_pass ? `TRC_REP_PASS : `TRC_REP_FAIL);

	// streaming and touchdown reports are held off from the accepted parameter byte until the calibration exchange returns to idle; liftoff is not gated
	wire rep_en  = (state == trc_pkg::CAL_IDLE) || (state == trc_pkg::CAL_PARAM);
	wire acc     = i_coord_valid && touch_s && rep_en;
	wire rise    = touch_s && !touch_d;
	wire fall    = !touch_s && touch_d;
	wire e_strm  = acc && (mode == `TRC_MODE_STREAM);
	wire e_td    = acc && (mode == `TRC_MODE_TOUCH) && (rise || td_pend);
	wire e_lift  = fall && (mode == `TRC_MODE_LIFT) && lift_have;
	wire next_rep = e_strm || e_td || e_lift;

	assign in_c[0] = i_coord_x; // R17
	assign in_c[1] = i_coord_y;

	genvar a;
	generate
		for (a = 0; a < 2; a++) begin : g_axis
			wire [10:0] d = {1'b0, in_c[a]} - {1'b0, prev_c[a]};
			wire [10:0] m = d[10] ? (~d + 11'h001) : d;
			assign move[a]   = (m >= {5'h00, focus}); // R1 R3
			assign filt_c[a] = move[a] ? in_c[a] : prev_c[a]; // R2
			always_ff @(posedge i_clk) begin
				if (!i_rst_n) begin
					prev_c[a] <= 10'h000;
					last_c[a] <= 10'h000;
				end else if (acc) begin
					if (move[a]) begin
						prev_c[a] <= in_c[a]; // R1
					end
					last_c[a] <= filt_c[a];
				end
			end
		end
	endgenerate

	genvar p;
	generate
		for (p = 0; p < NPTS; p++) begin : g_pt
			localparam logic [3:0] PI = 4'(p + 1);
			assign pt_need[p] = (PI <= par[7:4]);
			always_ff @(posedge i_clk) begin
				if (!i_rst_n) begin
					pt_ok[p] <= 1'b0;
					pt_x[p]  <= 10'h000;
					pt_y[p]  <= 10'h000;
				end else if (store && (par[3:0] == PI)) begin
					pt_ok[p] <= 1'b1; // R16
					pt_x[p]  <= i_coord_x;
					pt_y[p]  <= i_coord_y;
				end else if (param_take && (p_idx == 4'h1)) begin
					pt_ok[p] <= 1'b0;
				end
			end
		end
	endgenerate

	trc_cal_ref u_ref (
		.i_idx    (par[3:0]),
		.i_x      (i_coord_x),
		.i_y      (i_coord_y),
		.o_ref_x  (),
		.o_ref_y  (),
		.o_in_win (win_ok)
	);

	always_comb begin
		next_state = state;
		case (state)
			trc_pkg::CAL_IDLE: if (rx_idle && (i_rx_byte == `TRC_CMD_CAL)) next_state = trc_pkg::CAL_PARAM;
			trc_pkg::CAL_PARAM: if (i_rx_valid) next_state = param_ok ? trc_pkg::CAL_ECHO_OP : trc_pkg::CAL_IDLE; // R21
			trc_pkg::CAL_ECHO_OP: if (tx_done) next_state = trc_pkg::CAL_ECHO_PAR; // R11
			trc_pkg::CAL_ECHO_PAR: if (tx_done) next_state = trc_pkg::CAL_TOUCH; // R11
			trc_pkg::CAL_TOUCH: if (cal_take) next_state = trc_pkg::CAL_POINT;
			trc_pkg::CAL_POINT: if (tx_done) next_state = (pt_acc && last_pt) ? trc_pkg::CAL_TEST : trc_pkg::CAL_IDLE; // R14
			trc_pkg::CAL_TEST: if (tx_done) next_state = trc_pkg::CAL_IDLE;
			default: next_state = trc_pkg::CAL_IDLE;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			state <= trc_pkg::CAL_IDLE;
			par   <= 8'h00;
		end else begin
			state <= next_state;
			if (param_take) begin
				par <= i_rx_byte;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			pt_in  <= 1'b0;
			pt_chk <= 1'b0;
		end else if (cal_take) begin
			pt_in  <= win_ok; // R9 R18 R19
			pt_chk <= chk_en; // R12
		end
	end

	// the byte stands until the link takes it
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_tx_valid <= 1'b0;
			o_tx_byte  <= 8'h00;
		end else if (tx_load) begin
			o_tx_valid <= 1'b1;
			o_tx_byte  <= tx_sel;
		end else if (tx_done) begin
			o_tx_valid <= 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			test_done <= 1'b0;
			test_pass <= 1'b0;
		end else if ((state == trc_pkg::CAL_POINT) && tx_done && pt_acc && last_pt) begin
			test_done <= 1'b1; // R14
			test_pass <= self_pass;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			mode    <= `TRC_MODE_RST;
			chk_en  <= `TRC_CHK_RST;
			focus   <= `TRC_FOCUS_RST; // R3
			cal_sel <= 4'h0;
		end else begin
			if (wr_ctrl) begin
				chk_en <= i_pwdata[`TRC_CTRL_CHK_BIT];
				focus  <= i_pwdata[`TRC_CTRL_FOC_LSB +: 6];
				if (mode_ok) begin
					mode <= wr_mode; // R20
				end
			end else if (chk_tog) begin
				chk_en <= !chk_en; // R13
			end
			if (apb_wr && hit_sel) begin
				cal_sel <= i_pwdata[3:0];
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata  <= 32'h00000000;
		end else begin
			o_pready  <= apb_acc;
			o_pslverr <= apb_acc && !hit_any;
			o_prdata  <= (apb_acc && !i_pwrite) ? rd_mux : 32'h00000000;
		end
	end

	// touch level arrives from the panel, so it is synchronised first
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			touch_m   <= 1'b0;
			touch_s   <= 1'b0;
			touch_d   <= 1'b0;
			td_pend   <= 1'b0;
			lift_have <= 1'b0;
		end else begin
			touch_m   <= i_touch;
			touch_s   <= touch_m;
			touch_d   <= touch_s;
			td_pend   <= (rise || td_pend) && !e_td && !fall; // R5
			lift_have <= acc || (lift_have && !fall); // R4
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_rep_valid <= 1'b0;
			o_rep_x     <= 10'h000;
			o_rep_y     <= 10'h000;
		end else begin
			o_rep_valid <= next_rep; // R6 R20
			if (next_rep) begin
				o_rep_x <= e_lift ? last_c[0] : filt_c[0]; // R4
				o_rep_y <= e_lift ? last_c[1] : filt_c[1];
			end
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	wire strm_acc = acc && (mode == `TRC_MODE_STREAM);
	property p_focus_new;
		strm_acc && move[0] |=> o_rep_valid && (o_rep_x == $past(i_coord_x));
	endproperty
	a_focus_new: assert property (p_focus_new) else $error("moved x not reported"); // R1
	property p_focus_hold;
		strm_acc && !move[0] |=> o_rep_x == $past(prev_c[0]);
	endproperty
	a_focus_hold: assert property (p_focus_hold) else $error("small move not held"); // R2
	property p_focus_off;
		strm_acc && (focus == 6'h00) |=> o_rep_y == $past(i_coord_y);
	endproperty
	a_focus_off: assert property (p_focus_off) else $error("zero threshold filtered"); // R3
	property p_lift;
		(mode == `TRC_MODE_LIFT) && touch_s |=> !o_rep_valid;
	endproperty
	a_lift: assert property (p_lift) else $error("liftoff report while touched"); // R4
	property p_td_once;
		(mode == `TRC_MODE_TOUCH) && o_rep_valid |=> !o_rep_valid;
	endproperty
	a_td_once: assert property (p_td_once) else $error("touchdown report repeated"); // R5
	property p_stream;
		strm_acc |=> o_rep_valid;
	endproperty
	a_stream: assert property (p_stream) else $error("stream sample dropped"); // R6
	property p_no_touch;
		!touch_s && !touch_d |=> !o_rep_valid;
	endproperty
	a_no_touch: assert property (p_no_touch) else $error("report without touch"); // R20
	property p_echo;
		param_take |-> ##[1:2] (o_tx_valid && (o_tx_byte == `TRC_CMD_CAL));
	endproperty
	a_echo: assert property (p_echo) else $error("opcode not echoed"); // R11
	property p_window;
		(state == trc_pkg::CAL_POINT) && o_tx_valid && pt_chk |-> o_tx_byte == (pt_in ? `TRC_REP_OK : `TRC_REP_ERR);
	endproperty
	a_window: assert property (p_window) else $error("wrong point reply"); // R18 R19
	property p_unchk;
		(state == trc_pkg::CAL_POINT) && o_tx_valid && !pt_chk |-> o_tx_byte == `TRC_REP_UNCHK;
	endproperty
	a_unchk: assert property (p_unchk) else $error("unchecked reply wrong"); // R12
	property p_toggle;
		chk_tog && !wr_ctrl |=> chk_en != $past(chk_en);
	endproperty
	a_toggle: assert property (p_toggle) else $error("check not toggled"); // R13
	property p_test;
		(state == trc_pkg::CAL_TEST) && o_tx_valid |-> (o_tx_byte == `TRC_REP_PASS) || (o_tx_byte == `TRC_REP_FAIL);
	endproperty
	a_test: assert property (p_test) else $error("bad self-test reply"); // R14
	property p_bad_par;
		i_rx_valid && (state == trc_pkg::CAL_PARAM) && !param_ok |=> (state == trc_pkg::CAL_IDLE) && !o_tx_valid;
	endproperty
	a_bad_par: assert property (p_bad_par) else $error("bad parameter accepted"); // R21
	property p_tx_hold;
		o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_byte);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("tx byte dropped");
	c_stream: cover property (strm_acc ##1 o_rep_valid);
	c_point_ok: cover property ((state == trc_pkg::CAL_POINT) && tx_done && pt_in);
	c_pass: cover property ((state == trc_pkg::CAL_TEST) && tx_done && test_pass);
endmodule : trc_top

// ---- sim/trc_host_model.sv ----
// host touch driver model: sends command bytes, collects replies with random stalls
`timescale 1ns/1ps
module trc_host_model (
	input  wire logic       i_clk,
	input  wire logic       i_tx_valid,
	input  wire logic [7:0] i_tx_byte,
	output logic            o_tx_ready,
	output logic            o_rx_valid,
	output logic [7:0]      o_rx_byte
);
	logic [7:0] rx_q [$];
	initial begin
		o_tx_ready = 1'b0;
		o_rx_valid = 1'b0;
		o_rx_byte  = 8'h00;
	end
	// uneven reader so the reply path is held up at random
	always @(posedge i_clk) begin
		if (i_tx_valid && o_tx_ready)
			rx_q.push_back(i_tx_byte);
		o_tx_ready <= ($urandom % 3) == 0;
	end
	task automatic send(input logic [7:0] b);
		@(posedge i_clk);
		o_rx_valid <= 1'b1;
		o_rx_byte  <= b;
		@(posedge i_clk);
		o_rx_valid <= 1'b0;
		// idle line never repeats the last byte
		o_rx_byte  <= ~b;
	endtask : send
endmodule : trc_host_model

// ---- sim/touch_report_and_calibration_test.sv ----
// self-checking bench of the touch report and calibration block
`timescale 1ns/1ps
`include "trc_defs.svh"
module touch_report_and_calibration_test;
	logic                i_clk = 1'b0;
	logic                i_rst_n = 1'b0;
	logic                psel = 1'b0;
	logic                penable = 1'b0;
	logic                pwrite = 1'b0;
	logic [11:0]         paddr = 12'h000;
	logic [31:0]         pwdata = 32'h00000000;
	logic [31:0]         prdata;
	logic                pready;
	logic                pslverr;
	logic                touch = 1'b0;
	logic                cval = 1'b0;
	trc_pkg::trc_coord_t cx = 10'h000;
	trc_pkg::trc_coord_t cy = 10'h000;
	logic                rep_valid;
	trc_pkg::trc_coord_t rep_x;
	trc_pkg::trc_coord_t rep_y;
	logic                rx_valid;
	logic [7:0]          rx_byte;
	logic                tx_valid;
	logic [7:0]          tx_byte;
	logic                tx_ready;
	int                  n_fail = 0;
	int                  tests_run = 0;
	int                  cyc = 0;
	logic [5:0]          fv [3] = '{6'h04, 6'h00, 6'h3F};
	logic [9:0]          rfx [13] = '{10'h07F, 10'h37F, 10'h07F, 10'h1FF, 10'h37F, 10'h37F, 10'h1FF,
		10'h07F, 10'h1FF, 10'h26F, 10'h26F, 10'h13F, 10'h13F};
	logic [9:0]          rfy [13] = '{10'h07F, 10'h37F, 10'h37F, 10'h1FF, 10'h07F, 10'h1FF, 10'h37F,
		10'h1FF, 10'h07F, 10'h13F, 10'h26F, 10'h26F, 10'h13F};
	always #10 i_clk = ~i_clk;
	trc_top #(.NPTS(13)) i_dut (
		.i_clk         (i_clk),
		.i_rst_n       (i_rst_n),
		.i_psel        (psel),
		.i_penable     (penable),
		.i_pwrite      (pwrite),
		.i_paddr       (paddr),
		.i_pwdata      (pwdata),
		.o_prdata      (prdata),
		.o_pready      (pready),
		.o_pslverr     (pslverr),
		.i_touch       (touch),
		.i_coord_valid (cval),
		.i_coord_x     (cx),
		.i_coord_y     (cy),
		.o_rep_valid   (rep_valid),
		.o_rep_x       (rep_x),
		.o_rep_y       (rep_y),
		.i_rx_valid    (rx_valid),
		.i_rx_byte     (rx_byte),
		.o_tx_valid    (tx_valid),
		.o_tx_byte     (tx_byte),
		.i_tx_ready    (tx_ready)
	);
	trc_host_model i_host (
		.i_clk      (i_clk),
		.i_tx_valid (tx_valid),
		.i_tx_byte  (tx_byte),
		.o_tx_ready (tx_ready),
		.o_rx_valid (rx_valid),
		.o_rx_byte  (rx_byte)
	);
	task automatic conclude();
		$display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : conclude
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_fail++;
			conclude();
		end
	end
	task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		@(posedge i_clk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge i_clk);
		penable <= 1'b1;
		do
			@(posedge i_clk);
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic ctrl(input logic [1:0] m, input logic [5:0] f);
		logic [31:0] q;
		logic        e;
		apb(1'b1, `TRC_OFF_CTRL, {18'h00000, f, 3'h0, 1'b1, 2'h0, m}, q, e);
	endtask : ctrl
	// the report pulse lands one edge after the sample is launched and is read on the edge after that
	task automatic smp(input logic [9:0] x, input logic [9:0] y, output logic v);
		@(posedge i_clk);
		cval <= 1'b1;
		cx   <= x;
		cy   <= y;
		@(posedge i_clk);
		cval <= 1'b0;
		cx   <= ~x;
		cy   <= ~y;
		@(posedge i_clk);
		v = rep_valid;
	endtask : smp
	function automatic logic [9:0] foc(input logic [9:0] n, input logic [9:0] p, input logic [5:0] f);
		return (((n > p) ? n - p : p - n) >= 10'(f)) ? n : p;
	endfunction : foc
	// jumps open each touch so a per-touch restart of the filter reads the same
	function automatic logic [9:0] nxt(input logic [9:0] p, input int j, input logic [5:0] f);
		if (j == 0)
			return p + 10'h0C8;
		if (j == 1)
			return p + 10'(f);
		if (j == 2)
			return p - 10'(f) + 10'h001;
		return 10'(int'(p) + int'($urandom % 16) - 8);
	endfunction : nxt
	task automatic get(input logic [7:0] exp);
		int n;
		n = 0;
		while (i_host.rx_q.size() == 0 && n < 400) begin
			@(posedge i_clk);
			n++;
		end
		chk((i_host.rx_q.size() > 0) ? i_host.rx_q.pop_front() : 8'hXX, exp);
	endtask : get
	task automatic cal(input logic [7:0] par, input int dx, input int dy, input logic ce, input logic [7:0] fin);
		logic v;
		logic win;
		win = dx <= 127 && dx >= -127 && dy <= 127 && dy >= -127;
		i_host.send(`TRC_CMD_CAL);
		i_host.send(par);
		get(8'hBD);
		get(par);
		touch <= 1'b1;
		repeat (4) @(posedge i_clk);
		smp(10'(int'(rfx[par[3:0] - 1]) + dx), 10'(int'(rfy[par[3:0] - 1]) + dy), v);
		chk(v, 1'b0);
		get((ce && win) ? 8'hC4 : 8'hC8);
		if (fin != 8'h00)
			get(fin);
		touch <= 1'b0;
		repeat (4) @(posedge i_clk);
	endtask : cal
	initial begin
		logic [31:0] q;
		logic        e;
		logic        v;
		logic [9:0]  px;
		logic [9:0]  py;
		logic [9:0]  nx;
		logic [9:0]  ny;
		void'($urandom(8718));
		px = 10'h100;
		py = 10'h180;
		repeat (16) @(posedge i_clk);
		i_rst_n <= 1'b1;
		apb(1'b0, `TRC_OFF_CTRL, 32'h00000000, q, e);
		chk(q, 32'h00000412);
		foreach (fv[k]) begin
			ctrl(`TRC_MODE_STREAM, fv[k]);
			touch <= 1'b1;
			repeat (4) @(posedge i_clk);
			for (int j = 0; j < 8; j++) begin
				nx = nxt(px, j, fv[k]);
				ny = nxt(py, (j != 0) ? j ^ 3 : 0, fv[k]);
				smp(nx, ny, v);
				px = foc(nx, px, fv[k]);
				py = foc(ny, py, fv[k]);
				chk(v, 1'b1);
				chk({rep_y, rep_x}, {py, px});
			end
			touch <= 1'b0;
			repeat (4) @(posedge i_clk);
			smp(nx, ny, v);
			chk(v, 1'b0);
		end
		$display("test stream done");
		for (int m = 0; m < 2; m++) begin
			ctrl((m == 0) ? `TRC_MODE_TOUCH : `TRC_MODE_LIFT, 6'h04);
			touch <= 1'b1;
			repeat (4) @(posedge i_clk);
			for (int j = 0; j < 3; j++) begin
				px = px + 10'h0C8;
				py = py + 10'h0C8;
				smp(px, py, v);
				chk(v, m == 0 && j == 0);
				if (m == 0 && j == 0)
					chk({rep_y, rep_x}, {py, px});
			end
			touch <= 1'b0;
			for (int n = 0; n < 12 && rep_valid !== 1'b1; n++)
				@(posedge i_clk);
			chk(rep_valid, m == 1);
			if (m == 1)
				chk({rep_y, rep_x}, {py, px});
		end
		$display("test touchdown and liftoff done");
		ctrl(2'h3, 6'h04);
		apb(1'b0, `TRC_OFF_CTRL, 32'h00000000, q, e);
		chk(q[1:0], `TRC_MODE_LIFT);
		apb(1'b0, 12'h010, 32'h00000000, q, e);
		chk({e, q}, 33'h100000000);
		ctrl(`TRC_MODE_STREAM, 6'h04);
		i_host.send(`TRC_CMD_CAL);
		i_host.send(8'h31);
		i_host.send(`TRC_CMD_CAL);
		i_host.send(8'h23);
		i_host.send(`TRC_CMD_CAL);
		i_host.send(8'h20);
		repeat (60) @(posedge i_clk);
		chk(i_host.rx_q.size(), 0);
		cal(8'h21, 128, 0, 1'b1, 8'h00);
		cal(8'h21, 127, -127, 1'b1, 8'h00);
		cal(8'h22, -127, 127, 1'b1, 8'hCB);
		apb(1'b1, `TRC_OFF_CAL_SEL, 32'h00000001, q, e);
		apb(1'b0, `TRC_OFF_CAL_DATA, 32'h00000000, q, e);
		chk(q, 32'h830003FE);
		apb(1'b0, `TRC_OFF_STATUS, 32'h00000000, q, e);
		chk(q, 32'h0000000C);
		for (int i = 1; i <= 13; i++)
			cal({4'hD, 4'(i)}, int'($urandom % 255) - 127, int'($urandom % 255) - 127, 1'b1,
				(i == 13) ? 8'hCB : 8'h00);
		i_host.send(`TRC_CMD_CHK);
		apb(1'b0, `TRC_OFF_CTRL, 32'h00000000, q, e);
		chk(q[4], 1'b0);
		cal(8'h51, 400, 400, 1'b0, 8'h00);
		cal(8'h55, 0, 0, 1'b0, 8'hCC);
		for (int i = 1; i <= 5; i++)
			cal({4'h5, 4'(i)}, -20, 30, 1'b0, (i == 5) ? 8'hCB : 8'h00);
		$display("test calibration done");
		conclude();
	end
endmodule : touch_report_and_calibration_test
